// File: core/dpca_pkg.sv
// constants for the debug port cpu access block
// assumes one core clock at 200 mhz and a separate link clock
package dpca_pkg;

	////////////////////////////////////////////////////////////////////////
	// timing

	// core clock period in picoseconds
	localparam int unsigned CLK_PERIOD_PS = 5000;
	// length of the cpu reset pulse in nanoseconds
	localparam int unsigned RESET_TIME_NS = 100;
	// reset pulse in core cycles, rounded up
	localparam int unsigned RESET_CYCLES =
		(RESET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	////////////////////////////////////////////////////////////////////////
	// debug write address space

	localparam logic [7:0] ADDR_MASTER_CTL = 8'h11;
	localparam logic [7:0] ADDR_WR_UPPER = 8'h13;
	localparam logic [7:0] ADDR_WR_HIGH = 8'h14;
	localparam logic [7:0] ADDR_WR_LOW = 8'h15;
	localparam logic [7:0] ADDR_ACCESS_CMD = 8'h16;

	// master control fields
	localparam int unsigned MASTER_RESET_BIT = 7;
	localparam logic [7:0] MASTER_CTL_RESET = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// command codes and field layout

	localparam logic [7:0] CMD_SET_MODE = 8'h08;
	localparam logic [7:0] CMD_CLR_MODE = 8'h09;
	// bit 7 marks a write, bits 6:3 zero mark a register group access
	localparam int unsigned CMD_WRITE_BIT = 7;
	localparam int unsigned CMD_ZERO_MSB = 6;
	localparam int unsigned CMD_ZERO_LSB = 3;
	localparam int unsigned CMD_GROUP_MSB = 2;

	// operand byte lanes
	localparam int unsigned WORD_W = 24;
	localparam int unsigned SHORT_W = 16;
	localparam logic [7:0] PAD_BYTE = 8'h00;

	// register storage slots: groups 0..7 follow the codes
	localparam int unsigned SLOT_W = 4;
	localparam int unsigned SLOT_COUNT = 9;
	localparam logic [3:0] SLOT_LONG_SP = 4'h6;
	localparam logic [3:0] SLOT_SHORT_SP = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// core sequencer states

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FETCH = 2'b10
	} dpca_state_t;

endpackage

// File: core/dpca_regfile.sv
// cpu register storage: one write port, one registered read port
// assumes a single clock; no reset, contents undefined after power-up
`timescale 1ns/1ps

module dpca_regfile #(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned DEPTH = 9,
	parameter int unsigned IDX_W = 4
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [IDX_W-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data
);

	////////////////////////////////////////////////////////////////////////
	// elaboration check

	generate
		if (DEPTH < 1 || DEPTH > (1 << IDX_W)) begin : g_bad_depth
			$error("regfile depth does not fit the index width");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// storage

	// one word per register group
	logic [WIDTH-1:0] mem [DEPTH];

	// write port
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	// read port, data one cycle after the request
	always_ff @(posedge clk) begin
		if (rd_en) begin
			rd_data <= mem[rd_idx];
		end
	end

endmodule

// File: core/dpca_top.sv
// debug port cpu access: master control, write operand, access command
// assumes the link framer delivers byte writes on link_clk, and that the
// core clock clk runs the cpu side; each side has its own sync reset
//
// Operation
// - master control bit 7 set starts cpu reset
// - reset request bit clears itself after pulse
// - operand held as upper, high, low bytes
// - command register sits at 16h after operand
// - command write while not busy executes selected operation; while busy it is dropped
// - read commands load the three result bytes
// - write commands take data from operand bytes
// - codes 00-07 read the eight register groups
// - codes 80-87 write the same register groups
// - stack pointer follows the address width mode
`timescale 1ns/1ps

module dpca_top #(
	parameter int unsigned RESET_HOLD_CYCLES = dpca_pkg::RESET_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic link_clk,
	input wire logic link_rstn,
	input wire logic link_wr_en,
	input wire logic [7:0] link_addr,
	input wire logic [7:0] link_wr_data,
	output logic link_cmd_busy,
	output logic [7:0] read_result_upper,
	output logic [7:0] read_result_high,
	output logic [7:0] read_result_low,
	output logic cpu_reset_request,
	output logic wide_address_mode
);
	import dpca_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// elaboration check

	generate
		if (RESET_HOLD_CYCLES < 1) begin : g_bad_hold
			$error("reset hold must last at least one cycle");
		end
	endgenerate

	// width of the reset pulse counter
	localparam int unsigned CNT_W = $clog2(RESET_HOLD_CYCLES + 1);
	// width of one result lane
	localparam int unsigned BYTE_W = WORD_W - SHORT_W;

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	// register group read: bit 7 clear, bits 6:3 zero
	function automatic logic is_read_cmd(input logic [7:0] code);
		is_read_cmd = !code[CMD_WRITE_BIT] &&
			(code[CMD_ZERO_MSB:CMD_ZERO_LSB] == '0);
	endfunction

	// register group write: bit 7 set, bits 6:3 zero
	function automatic logic is_write_cmd(input logic [7:0] code);
		is_write_cmd = code[CMD_WRITE_BIT] &&
			(code[CMD_ZERO_MSB:CMD_ZERO_LSB] == '0);
	endfunction

	// storage slot of a group; the stack pointer slot depends on mode
	function automatic logic [SLOT_W-1:0] slot_of(input logic [7:0] code,
			input logic wide);
		logic [SLOT_W-1:0] slot;
		slot = {1'b0, code[CMD_GROUP_MSB:0]};
		if (slot == SLOT_LONG_SP && !wide) begin
			slot = SLOT_SHORT_SP;
		end
		slot_of = slot;
	endfunction

	// operand as written to a slot; short slots keep only low bits
	function automatic logic [WORD_W-1:0] fit_operand(
			input logic [SLOT_W-1:0] slot, input logic [WORD_W-1:0] op);
		if (slot == SLOT_SHORT_SP) begin
			fit_operand = {PAD_BYTE, op[SHORT_W-1:0]};
		end else begin
			fit_operand = op;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// link domain: write registers

	logic [7:0] write_operand_upper; // operand bits 23:16
	logic [7:0] write_operand_high; // operand bits 15:8
	logic [7:0] write_operand_low; // operand bits 7:0
	logic [7:0] cmd_code; // last accepted command, held while busy
	logic [WORD_W-1:0] cmd_operand; // operand snapshot for the command
	logic req_tgl; // flips once per accepted command
	logic rst_tgl; // flips once per reset request
	logic [2:0] ack_sync; // ack toggle synchroniser
	logic ack_seen; // last ack toggle value handled
	logic ack_event; // stable new ack from the core
	logic cmd_hit; // command byte accepted this cycle
	logic ack_tgl; // flips when a command is finished
	logic [WORD_W-1:0] result_word; // last read value for the link

	// command byte written while no command is in flight
	assign cmd_hit = link_wr_en && link_addr == ADDR_ACCESS_CMD &&
		!link_cmd_busy;

	// operand byte registers, loaded by byte writes
	always_ff @(posedge link_clk) begin
		if (!link_rstn) begin
			write_operand_upper <= PAD_BYTE;
			write_operand_high <= PAD_BYTE;
			write_operand_low <= PAD_BYTE;
		end else if (link_wr_en) begin
			// address decode of the three lanes
			unique case (link_addr)
				ADDR_WR_UPPER: begin
					write_operand_upper <= link_wr_data;
				end
				ADDR_WR_HIGH: begin
					write_operand_high <= link_wr_data;
				end
				ADDR_WR_LOW: begin
					write_operand_low <= link_wr_data;
				end
				default: begin
					// other addresses leave the operand alone
				end
			endcase
		end
	end

	// master control: only the reset bit acts, reserved bits are dropped
	always_ff @(posedge link_clk) begin
		if (!link_rstn) begin
			rst_tgl <= 1'b0;
		end else if (link_wr_en && link_addr == ADDR_MASTER_CTL &&
				link_wr_data[MASTER_RESET_BIT]) begin
			rst_tgl <= ~rst_tgl;
		end
	end

	// command capture: snapshot operand and hand over to the core
	always_ff @(posedge link_clk) begin
		if (!link_rstn) begin
			cmd_code <= PAD_BYTE;
			cmd_operand <= '0;
			req_tgl <= 1'b0;
		end else if (cmd_hit) begin
			cmd_code <= link_wr_data;
			// upper lane is most significant
			cmd_operand <= {write_operand_upper, write_operand_high,
				write_operand_low};
			req_tgl <= ~req_tgl;
		end
	end

	// ack toggle from the core, three stages
	always_ff @(posedge link_clk) begin
		if (!link_rstn) begin
			ack_sync <= 3'h0;
			ack_seen <= 1'b0;
		end else begin
			ack_sync <= {ack_sync[1:0], ack_tgl};
			if (ack_event) begin
				ack_seen <= ack_sync[2];
			end
		end
	end

	// a change counts once stages two and three agree
	assign ack_event = (ack_sync[1] == ack_sync[2]) &&
		(ack_sync[2] != ack_seen);

	// busy from command accept until the core answers
	always_ff @(posedge link_clk) begin
		if (!link_rstn) begin
			link_cmd_busy <= 1'b0;
		end else if (cmd_hit) begin
			link_cmd_busy <= 1'b1;
		end else if (ack_event) begin
			link_cmd_busy <= 1'b0;
		end
	end

	// result bytes, taken from the core word once the ack lands
	always_ff @(posedge link_clk) begin
		if (!link_rstn) begin
			read_result_upper <= PAD_BYTE;
			read_result_high <= PAD_BYTE;
			read_result_low <= PAD_BYTE;
		end else if (ack_event) begin
			// word is stable in the core until the next command
			read_result_upper <= result_word[WORD_W-1:SHORT_W];
			read_result_high <= result_word[SHORT_W-1:BYTE_W];
			read_result_low <= result_word[BYTE_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core domain: crossing of request and reset toggles

	logic [2:0] req_sync; // request toggle synchroniser
	logic req_seen; // last request toggle handled
	logic req_event; // stable new command from the link
	logic [2:0] rst_sync; // reset toggle synchroniser
	logic rst_seen; // last reset toggle handled
	logic rst_event; // stable new reset request

	// three stages per toggle, tracked against the last value handled
	always_ff @(posedge clk) begin
		if (!rstn) begin
			req_sync <= 3'h0;
			req_seen <= 1'b0;
			rst_sync <= 3'h0;
			rst_seen <= 1'b0;
		end else begin
			req_sync <= {req_sync[1:0], req_tgl};
			rst_sync <= {rst_sync[1:0], rst_tgl};
			if (req_event) begin
				req_seen <= req_sync[2];
			end
			if (rst_event) begin
				rst_seen <= rst_sync[2];
			end
		end
	end

	// new toggle value, counted once stages two and three agree
	assign req_event = (req_sync[1] == req_sync[2]) &&
		(req_sync[2] != req_seen);
	assign rst_event = (rst_sync[1] == rst_sync[2]) &&
		(rst_sync[2] != rst_seen);

	////////////////////////////////////////////////////////////////////////
	// core domain: cpu reset pulse

	logic [CNT_W-1:0] rst_cnt; // cycles left in the reset pulse

	// a new request restarts the pulse, so set wins over clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cpu_reset_request <= MASTER_CTL_RESET[MASTER_RESET_BIT];
			rst_cnt <= '0;
		end else if (rst_event) begin
			cpu_reset_request <= 1'b1;
			rst_cnt <= CNT_W'(RESET_HOLD_CYCLES - 1);
		end else if (cpu_reset_request) begin
			if (rst_cnt == '0) begin
				cpu_reset_request <= 1'b0;
			end else begin
				rst_cnt <= rst_cnt - 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core domain: command sequencer

	dpca_state_t state; // sequencer state
	dpca_state_t next_state; // state for the next edge
	logic mem_rd_en; // storage read request
	logic mem_wr_en; // storage write request
	logic [SLOT_W-1:0] mem_idx; // slot addressed by the command
	logic [WORD_W-1:0] mem_wr_data; // operand fitted to the slot
	logic [WORD_W-1:0] mem_rd_data; // storage read data

	// slot and write data from the held command
	assign mem_idx = slot_of(cmd_code, wide_address_mode);
	assign mem_wr_data = fit_operand(mem_idx, cmd_operand);

	// next state and storage strobes
	always_comb begin
		next_state = state;
		mem_rd_en = 1'b0;
		mem_wr_en = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (req_event && is_read_cmd(cmd_code)) begin
					mem_rd_en = 1'b1;
					next_state = ST_FETCH;
				end else if (req_event && is_write_cmd(cmd_code)) begin
					mem_wr_en = 1'b1;
				end
			end
			ST_FETCH: begin
				// read data is registered, ready now
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// answer: reads after fetch, everything else at once
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ack_tgl <= 1'b0;
			result_word <= '0;
		end else if (state == ST_FETCH) begin
			result_word <= mem_rd_data;
			ack_tgl <= ~ack_tgl;
		end else if (req_event && !is_read_cmd(cmd_code)) begin
			ack_tgl <= ~ack_tgl;
		end
	end

	// address width mode; reserved codes fall through untouched
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wide_address_mode <= 1'b0;
		end else if (req_event && state == ST_IDLE) begin
			if (cmd_code == CMD_SET_MODE) begin
				wide_address_mode <= 1'b1;
			end else if (cmd_code == CMD_CLR_MODE) begin
				wide_address_mode <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register group storage

	// one word per group, short stack pointer in its own slot
	dpca_regfile #(
		.WIDTH(WORD_W),
		.DEPTH(SLOT_COUNT),
		.IDX_W(SLOT_W)
	) u_regfile (
		.clk(clk),
		.wr_en(mem_wr_en),
		.wr_idx(mem_idx),
		.wr_data(mem_wr_data),
		.rd_en(mem_rd_en),
		.rd_idx(mem_idx),
		.rd_data(mem_rd_data)
	);

endmodule

// File: bench/dpca_checker.sv
// port checker for dpca_top
// assumes it is bound onto dpca_top; link and core domains
`timescale 1ns/1ps
module dpca_checker #(
	parameter int unsigned RESET_HOLD_CYCLES = 20
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic link_clk,
	input wire logic link_rstn,
	input wire logic link_wr_en,
	input wire logic [7:0] link_addr,
	input wire logic [7:0] link_wr_data,
	input wire logic link_cmd_busy,
	input wire logic [7:0] read_result_upper,
	input wire logic [7:0] read_result_high,
	input wire logic [7:0] read_result_low,
	input wire logic cpu_reset_request,
	input wire logic wide_address_mode
);
	logic [15:0] hi_cnt; // high cycles of the reset pulse so far
	wire logic cmd_wr = link_wr_en && link_addr == 8'h16; // command byte
	wire logic [23:0] rd = {read_result_upper, read_result_high,
		read_result_low};
	// count the pulse length, cleared while low
	always_ff @(posedge clk) begin
		if (!rstn || !cpu_reset_request)
			hi_cnt <= 16'h0000;
		else
			hi_cnt <= hi_cnt + 16'h0001;
	end
	////////////////////////////////////////
	sequence s_accept;
		cmd_wr && !link_cmd_busy;
	endsequence
	sequence s_busy_hold;
		link_cmd_busy [*3];
	endsequence
	property p_busy_rise;
		@(posedge link_clk) disable iff (!link_rstn) s_accept |=> link_cmd_busy;
	endproperty
	a_busy_rise: assert property (p_busy_rise)
		else $error("busy did not rise on a command");
	property p_busy_cause;
		@(posedge link_clk) disable iff (!link_rstn)
		$rose(link_cmd_busy) |-> $past(cmd_wr);
	endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("busy rose without a command");
	property p_busy_min;
		@(posedge link_clk) disable iff (!link_rstn)
		$rose(link_cmd_busy) |-> s_busy_hold;
	endproperty
	a_busy_min: assert property (p_busy_min)
		else $error("busy too short");
	property p_busy_end;
		@(posedge link_clk) disable iff (!link_rstn)
		$rose(link_cmd_busy) |-> ##[1:12] !link_cmd_busy;
	endproperty
	a_busy_end: assert property (p_busy_end)
		else $error("command never finished");
	property p_result_hold;
		@(posedge link_clk) disable iff (!link_rstn)
		!$fell(link_cmd_busy) |-> $stable(rd);
	endproperty
	a_result_hold: assert property (p_result_hold)
		else $error("results moved outside completion");
	property p_mode_cause;
		@(posedge clk) disable iff (!rstn)
		$changed(wide_address_mode) |-> link_cmd_busy;
	endproperty
	a_mode_cause: assert property (p_mode_cause)
		else $error("mode changed without a command");
	property p_rst_hold;
		@(posedge clk) disable iff (!rstn)
		cpu_reset_request && hi_cnt < RESET_HOLD_CYCLES - 1
		|=> cpu_reset_request;
	endproperty
	a_rst_hold: assert property (p_rst_hold)
		else $error("cpu reset pulse ended early");
	property p_rst_clear;
		@(posedge clk) disable iff (!rstn)
		$fell(cpu_reset_request) |-> hi_cnt >= RESET_HOLD_CYCLES;
	endproperty
	a_rst_clear: assert property (p_rst_clear)
		else $error("cpu reset pulse length wrong");
endmodule
bind dpca_top dpca_checker #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) u_chk (
	.clk(clk), .rstn(rstn), .link_clk(link_clk), .link_rstn(link_rstn),
	.link_wr_en(link_wr_en), .link_addr(link_addr),
	.link_wr_data(link_wr_data), .link_cmd_busy(link_cmd_busy),
	.read_result_upper(read_result_upper),
	.read_result_high(read_result_high), .read_result_low(read_result_low),
	.cpu_reset_request(cpu_reset_request),
	.wide_address_mode(wide_address_mode));

// File: bench/dpca_host.sv
// debug host model driving the link write bus
// assumes the bench calls its tasks; busy comes from dpca_top
`timescale 1ns/1ps
module dpca_host (
	input wire logic link_clk,
	input wire logic link_cmd_busy,
	output logic link_wr_en,
	output logic [7:0] link_addr,
	output logic [7:0] link_wr_data
);
	initial begin
		link_wr_en = 1'b0;
		link_addr = 8'h00;
		link_wr_data = 8'h00;
	end
	////////////////////////////////////////
	// one byte, held over the taking edge
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge link_clk);
		link_wr_en <= 1'b1;
		link_addr <= a;
		link_wr_data <= d;
		@(posedge link_clk);
	endtask
	// released lines show no stale byte
	task automatic idle();
		@(negedge link_clk);
		link_wr_en <= 1'b0;
		link_addr <= ~link_addr;
		link_wr_data <= ~link_wr_data;
	endtask
	// operand and command in one stream, then bounded wait on busy
	task automatic cmd(input logic [23:0] op, input logic [7:0] c,
		input bit extra, output bit ok);
		put(8'h13, op[23:16]);
		put(8'h14, op[15:8]);
		put(8'h15, op[7:0]);
		put(8'h16, c);
		if (extra)
			put(8'h16, 8'h00);
		idle();
		ok = 1'b0;
		for (int i = 0; i < 14 && !ok; i++) begin
			@(negedge link_clk);
			ok = (link_cmd_busy === 1'b0);
		end
	endtask
	// master control write, reserved bits kept zero
	task automatic ctl(input logic reset_bit);
		put(8'h11, {reset_bit, 7'h00});
		idle();
	endtask
endmodule

// File: bench/tb_dpca_top.sv
// self-checking bench for dpca_top
// assumes dpca_host as far side and the checker bound onto dpca_top
`timescale 1ns/1ps
module tb_dpca_top;
	localparam int unsigned HOLD = 4; // short cpu reset pulse
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic rstn = 1'b0;
	logic link_rstn = 1'b0;
	logic link_wr_en, link_cmd_busy, cpu_reset_request, wide_address_mode;
	logic [7:0] link_addr, link_wr_data;
	logic [7:0] read_result_upper, read_result_high, read_result_low;
	int miscompares = 0;
	int num_checks = 0;
	bit ok; // host finished within bound
	wire logic [23:0] rd = {read_result_upper, read_result_high,
		read_result_low};
	always #2.5 clk = ~clk;
	// link clock, offset so its edges never meet the core clock
	always begin
		#1.3;
		forever #15 link_clk = ~link_clk;
	end
	dpca_top #(.RESET_HOLD_CYCLES(HOLD)) DUT (.clk(clk), .rstn(rstn),
		.link_clk(link_clk), .link_rstn(link_rstn), .link_wr_en(link_wr_en),
		.link_addr(link_addr), .link_wr_data(link_wr_data),
		.link_cmd_busy(link_cmd_busy),
		.read_result_upper(read_result_upper),
		.read_result_high(read_result_high),
		.read_result_low(read_result_low),
		.cpu_reset_request(cpu_reset_request),
		.wide_address_mode(wide_address_mode));
	dpca_host host (.link_clk(link_clk), .link_cmd_busy(link_cmd_busy),
		.link_wr_en(link_wr_en), .link_addr(link_addr),
		.link_wr_data(link_wr_data));
	////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one command; a stuck busy ends the run
	task automatic run(input logic [23:0] op, input logic [7:0] c,
		input bit extra);
		host.cmd(op, c, extra, ok);
		check({23'h0, ok}, 24'h1);
		if (!ok)
			stop_test();
	endtask
	task automatic t_cpu_reset();
		int n;
		n = 0;
		host.ctl(1'b0);
		repeat (12) @(negedge clk);
		check({23'h0, cpu_reset_request}, 24'h0);
		host.ctl(1'b1);
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			if (cpu_reset_request === 1'b1)
				n++;
		end
		check(24'(n), 24'(HOLD));
		check({23'h0, cpu_reset_request}, 24'h0);
		$display("test cpu_reset done");
	endtask
	// every group written then read back, short stack pointer in mode 0
	task automatic t_groups();
		logic [23:0] v;
		for (int g = 0; g < 8; g++) begin
			v = {8'h10 + 8'(g), 8'ha5 ^ 8'(g), 8'h3c + 8'(g)};
			run(v, 8'h80 | 8'(g), 1'b0);
			run(24'h0, 8'(g), 1'b0);
			check(rd, (g == 6) ? {8'h00, v[15:0]} : v);
		end
		$display("test groups done");
	endtask
	task automatic t_mode();
		run(24'h0, 8'h08, 1'b0);
		check({23'h0, wide_address_mode}, 24'h1);
		run(24'h123456, 8'h86, 1'b0);
		run(24'h0, 8'h06, 1'b0);
		check(rd, 24'h123456);
		run(24'h0, 8'h88, 1'b0);
		run(24'h0, 8'h89, 1'b0);
		check(rd, 24'h123456);
		check({23'h0, wide_address_mode}, 24'h1);
		run(24'h0, 8'h06, 1'b0);
		check(rd, 24'h123456);
		run(24'h0, 8'h09, 1'b0);
		check({23'h0, wide_address_mode}, 24'h0);
		run(24'h0, 8'h06, 1'b0);
		check(rd, 24'h00a342);
		run(24'hfedcba, 8'h87, 1'b1);
		check(rd, 24'h00a342);
		run(24'h0, 8'h07, 1'b0);
		check(rd, 24'hfedcba);
		$display("test mode done");
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		@(negedge link_clk);
		link_rstn = 1'b1;
		repeat (3) @(negedge link_clk);
		check(rd, 24'h0);
		check({22'h0, cpu_reset_request, wide_address_mode}, 24'h0);
		t_cpu_reset();
		t_groups();
		t_mode();
		stop_test();
	end
endmodule
